// >>> strobe_timer_pkg.sv
// constants shared by the strobe-mode timer channel and its helpers
package strobe_timer_pkg;

   // ***************************************************************
   // widths
   // ***************************************************************
   localparam int CNT_W = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SYNC_STAGES = 2;

   // ***************************************************************
   // register byte offsets
   // ***************************************************************
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_VALUE = 8'h0c;

   // ***************************************************************
   // control word fields
   // ***************************************************************
   localparam int CTL_BCD_BIT = 0;
   localparam int CTL_MODE_LSB = 1;
   localparam int CTL_ACC_LSB = 4;

   localparam logic [2:0] MODE_SW_STROBE = 3'h4;
   localparam logic [2:0] MODE_HW_STROBE = 3'h5;

   localparam logic [1:0] ACC_LATCH = 2'h0;
   localparam logic [1:0] ACC_LOW = 2'h1;
   localparam logic [1:0] ACC_HIGH = 2'h2;
   localparam logic [1:0] ACC_BOTH = 2'h3;

   // ***************************************************************
   // status word fields
   // ***************************************************************
   localparam int ST_OUT_BIT = 0;
   localparam int ST_WRITTEN_BIT = 1;
   localparam int ST_HALF_BIT = 2;
   localparam int ST_RUN_BIT = 3;
   localparam int ST_ARMED_BIT = 4;
   localparam int ST_PEND_BIT = 5;
   localparam int ST_MODE_LSB = 8;
   localparam int ST_ACC_LSB = 12;
   localparam int ST_BCD_BIT = 14;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [2:0] RST_MODE = 3'h0;
   localparam logic [1:0] RST_ACC = 2'h1;
   localparam logic [15:0] RST_COUNT = 16'h0000;

endpackage

// >>> decrement_if.sv
// carrier between the channel and its decrement unit
`timescale 1ns/1ps
interface decrement_if;
   logic [strobe_timer_pkg::CNT_W-1:0] value;
   logic [strobe_timer_pkg::CNT_W-1:0] result;
   logic bcd;
   modport user (output value, output bcd, input result);
   modport unit (input value, input bcd, output result);
endinterface

// >>> bit_sync.sv
// two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ps
module bit_sync (
   // clock, reset, freeze
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // level in and out
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed {
      logic meta;
      logic stable;
   } sync_st_t;

   sync_st_t q;
   sync_st_t d;

   always_comb begin
      d = q;
      d.meta = async_in;
      d.stable = q.meta;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign sync_out = q.stable;
endmodule // bit_sync

// >>> count_decrement.sv
// one-step down count in binary or bcd, wrapping below zero
`timescale 1ns/1ps
module count_decrement #(
   parameter int CNT_W = strobe_timer_pkg::CNT_W
) (
   // value in, value minus one out
   decrement_if.unit dif
);
   localparam int DIGITS = CNT_W / 4;

   if ((CNT_W % 4) != 0 || CNT_W != strobe_timer_pkg::CNT_W) begin : g_bad_width
      $error("count_decrement: width must match the channel and hold whole digits");
   end

   logic [CNT_W-1:0] bcd_res;
   logic borrow;
   logic [3:0] digit;

   // zero wraps to all nines, as the binary path wraps to all ones
   always_comb begin
      bcd_res = '0;
      borrow = 1'b1;
      digit = 4'h0;
      for (int i = 0; i < DIGITS; i++) begin
         digit = dif.value[4*i +: 4];
         if (borrow && digit == 4'h0) begin
            bcd_res[4*i +: 4] = 4'h9;
         end else if (borrow) begin
            bcd_res[4*i +: 4] = digit - 4'h1;
            borrow = 1'b0;
         end else begin
            bcd_res[4*i +: 4] = digit;
         end
      end
   end

   assign dif.result = dif.bcd ? bcd_res : dif.value - {{(CNT_W-1){1'b0}}, 1'b1};
endmodule // count_decrement

// >>> strobe_timer.sv
// one timer channel in software- and hardware-triggered strobe modes, apb slave
`timescale 1ns/1ps
module strobe_timer (
   // clock, reset, freeze
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [strobe_timer_pkg::ADDR_W-1:0] paddr,
   input wire logic [strobe_timer_pkg::DATA_W-1:0] pwdata,
   output logic [strobe_timer_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // counting pins
   input wire logic count_clk,
   input wire logic gate,
   output logic cnt_out
);
   localparam int W = strobe_timer_pkg::CNT_W;

   if (W != 16) begin : g_bad_width
      $error("strobe_timer: the count is loaded as two bytes and must be 16 bits");
   end

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [strobe_timer_pkg::DATA_W-1:0] prdata;
      logic [2:0] mode;
      logic [1:0] access;
      logic bcd;
      logic [W-1:0] preset;
      logic half;
      logic written;
      logic load_pend;
      logic trig_pend;
      logic [W-1:0] count;
      logic armed;
      logic running;
      logic out;
      logic ck_prev;
      logic gate_prev;
   } timer_st_t;

   timer_st_t q;
   timer_st_t d;

   logic ck_s;
   logic gate_s;
   logic ck_rise;
   logic gate_rise;
   logic sw_mode;
   logic hw_mode;
   logic apb_setup;
   logic apb_access;
   logic wr_ctl;
   logic wr_cnt;
   logic cnt_done;
   logic mapped;
   logic [7:0] wbyte;
   logic [strobe_timer_pkg::DATA_W-1:0] rd_word;

   decrement_if dif ();

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   // both pins are asynchronous; the count clock is sampled, not used as a clock,
   // so it must run well below a quarter of pclk
   bit_sync u_sync_ck (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .async_in(count_clk),
      .sync_out(ck_s)
   );

   bit_sync u_sync_gate (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .async_in(gate),
      .sync_out(gate_s)
   );

   count_decrement #(
      .CNT_W(W)
   ) u_dec (
      .dif(dif)
   );

   assign dif.value = q.count;
   assign dif.bcd = q.bcd;

   // ***************************************************************
   // decode
   // ***************************************************************
   assign ck_rise = ck_s & ~q.ck_prev;
   assign gate_rise = gate_s & ~q.gate_prev;
   assign sw_mode = (q.mode == strobe_timer_pkg::MODE_SW_STROBE);
   assign hw_mode = (q.mode == strobe_timer_pkg::MODE_HW_STROBE);
   assign apb_setup = psel & ~penable;
   assign apb_access = psel & penable & q.pready;
   assign wr_ctl = apb_access & pwrite & (paddr == strobe_timer_pkg::OFS_CONTROL);
   assign wr_cnt = apb_access & pwrite & (paddr == strobe_timer_pkg::OFS_COUNT);
   assign wbyte = pwdata[7:0];

   // a whole count is in once the last byte of the access pattern lands
   assign cnt_done = wr_cnt &
                     ((q.access != strobe_timer_pkg::ACC_BOTH) || q.half);

   always_comb begin
      mapped = 1'b1;
      rd_word = '0;
      case (paddr)
         strobe_timer_pkg::OFS_CONTROL: begin
            rd_word[strobe_timer_pkg::CTL_BCD_BIT] = q.bcd;
            rd_word[strobe_timer_pkg::CTL_MODE_LSB +: 3] = q.mode;
            rd_word[strobe_timer_pkg::CTL_ACC_LSB +: 2] = q.access;
         end
         strobe_timer_pkg::OFS_COUNT: begin
            rd_word[W-1:0] = q.preset;
         end
         strobe_timer_pkg::OFS_STATUS: begin
            rd_word[strobe_timer_pkg::ST_OUT_BIT] = q.out;
            rd_word[strobe_timer_pkg::ST_WRITTEN_BIT] = q.written;
            rd_word[strobe_timer_pkg::ST_HALF_BIT] = q.half;
            rd_word[strobe_timer_pkg::ST_RUN_BIT] = q.running;
            rd_word[strobe_timer_pkg::ST_ARMED_BIT] = q.armed;
            rd_word[strobe_timer_pkg::ST_PEND_BIT] = q.load_pend | q.trig_pend;
            rd_word[strobe_timer_pkg::ST_MODE_LSB +: 3] = q.mode;
            rd_word[strobe_timer_pkg::ST_ACC_LSB +: 2] = q.access;
            rd_word[strobe_timer_pkg::ST_BCD_BIT] = q.bcd;
         end
         strobe_timer_pkg::OFS_VALUE: begin
            rd_word[W-1:0] = q.count;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      d = q;
      d.ck_prev = ck_s;
      d.gate_prev = gate_s;

      // bus: answer in the first access cycle, nothing else waits
      d.pready = 1'b0;
      if (apb_setup) begin
         d.pready = 1'b1;
         d.pslverr = ~mapped;
         d.prdata = pwrite ? '0 : rd_word;
      end else if (apb_access) begin
         d.pslverr = 1'b0;
         d.prdata = '0;
      end

      // counting, on each rising count clock
      if (ck_rise) begin
         if (!q.out) begin
            d.out = 1'b1;
         end
         if (sw_mode && q.load_pend) begin
            d.count = q.preset;
            d.load_pend = 1'b0;
            d.armed = 1'b1;
            d.running = 1'b1;
         end else if (hw_mode && q.trig_pend) begin
            d.count = q.preset;
            d.trig_pend = 1'b0;
            d.armed = 1'b1;
            d.running = 1'b1;
         end else if (q.running && (hw_mode || gate_s)) begin
            // gate low holds the count in software mode only
            d.count = dif.result;
            if (q.armed && dif.result == '0) begin
               d.out = 1'b0;
               d.armed = 1'b0;
            end
         end
      end

      // a trigger needs a complete count; a later one restarts the countdown
      if (hw_mode && gate_rise && q.written) begin
         d.trig_pend = 1'b1;
      end

      // count port: in hardware mode only the preset changes
      if (wr_cnt) begin
         case (q.access)
            strobe_timer_pkg::ACC_LOW: begin
               d.preset = {8'h00, wbyte};
            end
            strobe_timer_pkg::ACC_HIGH: begin
               d.preset = {wbyte, 8'h00};
            end
            strobe_timer_pkg::ACC_BOTH: begin
               if (q.half) begin
                  d.preset[15:8] = wbyte;
               end else begin
                  d.preset[7:0] = wbyte;
               end
               d.half = ~q.half;
            end
            default: begin
               d.preset = q.preset;
            end
         endcase
      end
      if (cnt_done) begin
         d.written = 1'b1;
         if (sw_mode) begin
            d.load_pend = 1'b1;
         end
      end

      // control word; the latch pattern does not reprogram the channel
      if (wr_ctl && pwdata[strobe_timer_pkg::CTL_ACC_LSB +: 2] != strobe_timer_pkg::ACC_LATCH) begin
         d.mode = pwdata[strobe_timer_pkg::CTL_MODE_LSB +: 3];
         d.access = pwdata[strobe_timer_pkg::CTL_ACC_LSB +: 2];
         d.bcd = pwdata[strobe_timer_pkg::CTL_BCD_BIT];
         d.half = 1'b0;
         d.written = 1'b0;
         d.load_pend = 1'b0;
         d.trig_pend = 1'b0;
         d.armed = 1'b0;
         d.running = 1'b0;
         d.out = 1'b1;
      end
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.pready <= 1'b0;
         q.pslverr <= 1'b0;
         q.prdata <= '0;
         q.mode <= strobe_timer_pkg::RST_MODE;
         q.access <= strobe_timer_pkg::RST_ACC;
         q.bcd <= 1'b0;
         q.preset <= strobe_timer_pkg::RST_COUNT;
         q.half <= 1'b0;
         q.written <= 1'b0;
         q.load_pend <= 1'b0;
         q.trig_pend <= 1'b0;
         q.count <= strobe_timer_pkg::RST_COUNT;
         q.armed <= 1'b0;
         q.running <= 1'b0;
         q.out <= 1'b1;
         q.ck_prev <= 1'b0;
         q.gate_prev <= 1'b0;
      end else if (ce) begin
         q <= d;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign cnt_out = q.out;
endmodule // strobe_timer

// >>> strobe_timer_asserts.sv
// concurrent checks on the strobe timer ports
`timescale 1ns/1ps
module strobe_timer_asserts (
   // clock, reset, freeze
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [strobe_timer_pkg::ADDR_W-1:0] paddr,
   input wire logic [strobe_timer_pkg::DATA_W-1:0] pwdata,
   input wire logic [strobe_timer_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins
   input wire logic count_clk,
   input wire logic gate,
   input wire logic cnt_out
);
   // ***************************************************************
   // properties
   // ***************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable && ce;
   endsequence
   // the latch pattern leaves the channel alone, so it is no mode write
   sequence s_ctl_wr;
      psel && penable && pready && pwrite && ce && paddr == strobe_timer_pkg::OFS_CONTROL
         && pwdata[strobe_timer_pkg::CTL_ACC_LSB +: 2] != strobe_timer_pkg::ACC_LATCH;
   endsequence
   // low phase spans one count clock, which the bench runs at 8 pclk
   sequence s_low;
      !cnt_out [*7] ##[1:2] cnt_out;
   endsequence
   AST_READY: assert property (s_setup ##1 ce |-> pready) else $error("ready late");
   AST_READY_ONE: assert property (pready |=> !pready) else $error("ready too long");
   AST_UNMAPPED: assert property (pready && paddr > strobe_timer_pkg::OFS_VALUE
      |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
   AST_MAPPED: assert property (pready && !pwrite && paddr[1:0] == 2'h0
      && paddr <= strobe_timer_pkg::OFS_VALUE |-> !pslverr) else $error("mapped refused");
   AST_WR_ZERO: assert property (pready && pwrite |-> prdata == 32'h0) else $error("wr data");
   AST_RST: assert property ($rose(presetn) |-> cnt_out && !pready) else $error("reset out");
   AST_CTL_HIGH: assert property (s_ctl_wr |=> cnt_out) else $error("mode not high");
   AST_STROBE_LEN: assert property ($fell(cnt_out) |-> s_low) else $error("strobe len");
   AST_STROBE_GAP: assert property ($rose(cnt_out) |-> cnt_out [*8]) else $error("gap");
endmodule // strobe_timer_asserts

bind strobe_timer strobe_timer_asserts i_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_clk(count_clk),
   .gate(gate), .cnt_out(cnt_out));

// >>> apb_host.sv
// apb host model that programs the timer channel
`timescale 1ns/1ps
module apb_host (
   // clock
   input wire logic pclk,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [strobe_timer_pkg::ADDR_W-1:0] paddr,
   output logic [strobe_timer_pkg::DATA_W-1:0] pwdata,
   input wire logic [strobe_timer_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   function automatic logic [31:0] ctl(input logic [2:0] md, input logic [1:0] ac, input logic bc);
      return {26'h0, ac, md, bc};
   endfunction
   // entered just after a rising edge; leaves one edge after release
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no wait-state count is assumed; only the bench watchdog ends a stuck access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines must not keep looking valid
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask
endmodule // apb_host

// >>> tb_strobe_timer.sv
// self-checking bench for the strobe timer channel
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; \
   $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module tb_strobe_timer;
   logic pclk, presetn, ce, count_clk, gate, psel, penable, pwrite, pready, pslverr, cnt_out, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [2:0] div_q;
   int mismatches, checks, seed, rises, strobes, r0, rl, s0, n, m;
   strobe_timer i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .count_clk(count_clk), .gate(gate), .cnt_out(cnt_out));
   apb_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // count clock of 8 pclk keeps the pin far slower than its synchroniser
   always @(posedge pclk) begin
      div_q <= div_q + 3'h1;
      count_clk <= div_q[2];
   end
   always @(posedge count_clk) rises++;
   always @(negedge cnt_out) strobes++;
   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic results;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic fall_pt;
      @(negedge count_clk);
      @(posedge pclk);
      r0 = rises;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a);
      i_host.xfer(1'b0, a, 32'h0, q, e);
   endtask
   task automatic strobe_in(input int ex);
      int t;
      for (t = 0; t < 4000 && cnt_out !== 1'b0; t++) @(posedge pclk);
      `CHK("rises to strobe", ex, rises - r0)
   endtask
   function automatic logic [15:0] exp_val(input int v, input int k, input logic bcd);
      int x;
      x = v - k;
      if (bcd !== 1'b1) return 16'(x);
      x = (x % 10000 + 10000) % 10000;
      return 16'((x / 1000) << 12 | (x / 100 % 10) << 8 | (x / 10 % 10) << 4 | x % 10);
   endfunction
   function automatic int pick(input int lo, input int span);
      return lo + int'($unsigned($random(seed)) % span);
   endfunction
   // ***************************************************************
   // tests
   // ***************************************************************
   initial begin
      seed = 71830;
      presetn = 1'b0;
      ce = 1'b1;
      gate = 1'b0;
      div_q = 3'h0;
      count_clk = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(strobe_timer_pkg::OFS_STATUS);
      `CHK("status", (32'(strobe_timer_pkg::RST_ACC) << strobe_timer_pkg::ST_ACC_LSB) | 32'h1, q)
      rd(8'h40);
      `CHK("unmapped err", 1'b1, e)
      `CHK("unmapped data", 32'h0, q)
      $display("test reset done");
      for (int bi = 0; bi < 2; bi++) begin
         wr(strobe_timer_pkg::OFS_CONTROL, i_host.ctl(strobe_timer_pkg::MODE_SW_STROBE,
            strobe_timer_pkg::ACC_LOW, bi[0]));
         gate <= 1'b1;
         n = bi ? pick(1, 9) : pick(1, 15);
         s0 = strobes;
         fall_pt;
         wr(strobe_timer_pkg::OFS_COUNT, 32'(n));
         strobe_in(n + 1);
         rl = r0;
         repeat (pick(2, 3)) fall_pt;
         // the first rise after the write loads the preset rather than counting down, so it is left out
         m = rises - rl - 1;
         rd(strobe_timer_pkg::OFS_VALUE);
         `CHK("wrap value", exp_val(n, m, bi[0]), q[15:0])
         `CHK("sw strobes", 1, strobes - s0)
      end
      $display("test software strobe done");
      gate <= 1'b0;
      n = pick(1, 9);
      s0 = strobes;
      fall_pt;
      wr(strobe_timer_pkg::OFS_COUNT, 32'(n));
      repeat (3) fall_pt;
      rd(strobe_timer_pkg::OFS_VALUE);
      `CHK("held value", 16'(n), q[15:0])
      gate <= 1'b1;
      strobe_in(n);
      $display("test gate low done");
      // a frozen channel misses the count clock rises outright, two of them here
      n = pick(1, 9);
      fall_pt;
      wr(strobe_timer_pkg::OFS_COUNT, 32'(n));
      rl = r0;
      fall_pt;
      ce <= 1'b0;
      repeat (2) fall_pt;
      ce <= 1'b1;
      r0 = rl;
      strobe_in(n + 3);
      $display("test freeze done");
      wr(strobe_timer_pkg::OFS_CONTROL, i_host.ctl(strobe_timer_pkg::MODE_SW_STROBE,
         strobe_timer_pkg::ACC_BOTH, 1'b0));
      s0 = strobes;
      fall_pt;
      wr(strobe_timer_pkg::OFS_COUNT, 32'(n));
      repeat (3) fall_pt;
      rd(strobe_timer_pkg::OFS_STATUS);
      `CHK("half", 1'b1, q[strobe_timer_pkg::ST_HALF_BIT])
      `CHK("no early load", 0, strobes - s0)
      `CHK("not started", 1'b0, q[strobe_timer_pkg::ST_RUN_BIT])
      fall_pt;
      wr(strobe_timer_pkg::OFS_COUNT, 32'h0);
      strobe_in(n + 1);
      $display("test two byte done");
      wr(strobe_timer_pkg::OFS_CONTROL, i_host.ctl(strobe_timer_pkg::MODE_HW_STROBE,
         strobe_timer_pkg::ACC_LOW, 1'b0));
      gate <= 1'b0;
      s0 = strobes;
      fall_pt;
      gate <= 1'b1;
      repeat (4) fall_pt;
      gate <= 1'b0;
      n = pick(3, 12);
      wr(strobe_timer_pkg::OFS_COUNT, 32'(n));
      repeat (3) fall_pt;
      rd(strobe_timer_pkg::OFS_STATUS);
      `CHK("no start", 0, strobes - s0)
      `CHK("not running", 1'b0, q[strobe_timer_pkg::ST_RUN_BIT])
      fall_pt;
      gate <= 1'b1;
      strobe_in(n + 1);
      fall_pt;
      gate <= 1'b0;
      fall_pt;
      gate <= 1'b1;
      fall_pt;
      gate <= 1'b0;
      s0 = strobes;
      fall_pt;
      gate <= 1'b1;
      strobe_in(n + 1);
      `CHK("hw strobes", 1, strobes - s0)
      fall_pt;
      gate <= 1'b0;
      fall_pt;
      gate <= 1'b1;
      rl = r0;
      m = n + pick(1, 5);
      fall_pt;
      wr(strobe_timer_pkg::OFS_COUNT, 32'(m));
      r0 = rl;
      strobe_in(n + 1);
      fall_pt;
      gate <= 1'b0;
      fall_pt;
      gate <= 1'b1;
      strobe_in(m + 1);
      $display("test hardware strobe done");
      repeat (20) @(posedge pclk);
      results();
   end
   initial begin
      #200000;
      mismatches++;
      results();
   end
endmodule // tb_strobe_timer
